//--- logic/cac_top.sv
// compare converter control: registers, comparison sequencer and shared pin steering
//
// Summary of operation
// - control bit 7 reads 1 when the selected input is above the reference
// - bits 6:5 pick the input: 00 reserved, 01/10/11 route inputs zero/one/two
// - writing 1 to bit 4 starts one comparison; 0 starts nothing
// - bits 3:0 drive the reference DAC code, level is supply/32 times code+1
// - pin function bits 2:0 set each shared pin analog (1) or open-drain port (0)
// - pin function bits 7:3 have no function and read zero
// - a comparison completes 8 machine cycles after its start
// - the start bit clears itself and always reads 0
`timescale 1ns/1ps
module cac_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [cac_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cac_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_above_in,
  output cac_pkg::cac_analog_t analog_ctrl,
  output logic [cac_pkg::PIN_N-1:0] analog_pin_select,
  input wire logic [cac_pkg::PIN_N-1:0] port_drive_low,
  input wire logic [cac_pkg::PIN_N-1:0] pin_i,
  output logic [cac_pkg::PIN_N-1:0] pin_o,
  output logic [cac_pkg::PIN_N-1:0] pin_oe,
  output logic [cac_pkg::PIN_N-1:0] port_in,
  output logic compare_busy
);
  logic [cac_pkg::CH_W-1:0] channel_select;
  logic [cac_pkg::REF_W-1:0] reference_code;
  logic compare_above_flag;
  logic [cac_pkg::PIN_N-1:0] pin_select;
  cac_pkg::cac_state_t state;
  logic [cac_pkg::MC_CNT_W-1:0] mc_div;
  logic [cac_pkg::CMP_CNT_W-1:0] mc_count;
  logic mc_tick;
  logic compare_done;
  logic wr_take;
  logic rd_take;
  logic start_req;
  logic [cac_pkg::PIN_N:0] synced;

  // address match helper, used by both channels
  function automatic logic is_addr(
    input logic [cac_pkg::ADDR_W-1:0] addr,
    input logic [cac_pkg::ADDR_W-1:0] reg_addr
  );
    return addr == reg_addr;
  endfunction : is_addr

  // comparator output and port pins arrive from outside the clock domain
  cac_sync3 #(
    .WIDTH(cac_pkg::PIN_N + 1)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({pin_i, compare_above_in}),
    .level(synced)
  );

  // write channel: address and data taken together, one response outstanding
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign rd_take = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_take;

  assign start_req = wr_take && s_axi_wstrb[0]
    && is_addr(s_axi_awaddr, cac_pkg::CTRL_ADDR)
    && s_axi_wdata[cac_pkg::START_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cac_pkg::RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      if (is_addr(s_axi_awaddr, cac_pkg::CTRL_ADDR)
          || is_addr(s_axi_awaddr, cac_pkg::PINFN_ADDR)) begin
        s_axi_bresp <= cac_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= cac_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_select <= cac_pkg::CH_RESET;
      reference_code <= cac_pkg::REF_RESET;
    end else if (wr_take && s_axi_wstrb[0] && is_addr(s_axi_awaddr, cac_pkg::CTRL_ADDR)) begin
      channel_select <= s_axi_wdata[cac_pkg::CH_HI_BIT:cac_pkg::CH_LO_BIT];
      reference_code <= s_axi_wdata[cac_pkg::REF_HI_BIT:cac_pkg::REF_LO_BIT];
    end
  end

  // pin function register; upper bits are not stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_select <= cac_pkg::PINFN_RESET;
    end else if (wr_take && s_axi_wstrb[0] && is_addr(s_axi_awaddr, cac_pkg::PINFN_ADDR)) begin
      pin_select <= s_axi_wdata[cac_pkg::PIN_HI_BIT:cac_pkg::PIN_LO_BIT];
    end
  end

  // machine cycle divider, realigned at each start
  assign mc_tick = (mc_div == cac_pkg::MC_LAST);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mc_div <= '0;
    end else if (start_req || mc_tick) begin
      mc_div <= '0;
    end else begin
      mc_div <= mc_div + 1'b1;
    end
  end

  // comparison sequencer; a new start restarts a running comparison
  assign compare_done = (state == cac_pkg::CAC_BUSY) && mc_tick
    && (mc_count == cac_pkg::CMP_LAST);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= cac_pkg::CAC_IDLE;
      mc_count <= '0;
    end else begin
      case (state)
        cac_pkg::CAC_IDLE: begin
          if (start_req) begin
            state <= cac_pkg::CAC_BUSY;
            mc_count <= '0;
          end
        end
        cac_pkg::CAC_BUSY: begin
          if (start_req) begin
            mc_count <= '0;
          end else if (compare_done) begin
            state <= cac_pkg::CAC_IDLE;
            mc_count <= '0;
          end else if (mc_tick) begin
            mc_count <= mc_count + 1'b1;
          end
        end
        default: begin
          state <= cac_pkg::CAC_IDLE;
          mc_count <= '0;
        end
      endcase
    end
  end

  // result latched only when a comparison completes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compare_above_flag <= cac_pkg::ABOVE_RESET;
    end else if (compare_done && !start_req) begin
      compare_above_flag <= synced[0];
    end
  end

  // read channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cac_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cac_pkg::RESP_OKAY;
      if (is_addr(s_axi_araddr, cac_pkg::CTRL_ADDR)) begin
        s_axi_rdata[cac_pkg::ABOVE_BIT] <= compare_above_flag;
        s_axi_rdata[cac_pkg::CH_HI_BIT:cac_pkg::CH_LO_BIT] <= channel_select;
        s_axi_rdata[cac_pkg::START_BIT] <= 1'b0;
        s_axi_rdata[cac_pkg::REF_HI_BIT:cac_pkg::REF_LO_BIT] <= reference_code;
      end else if (is_addr(s_axi_araddr, cac_pkg::PINFN_ADDR)) begin
        s_axi_rdata[cac_pkg::PIN_HI_BIT:cac_pkg::PIN_LO_BIT] <= pin_select;
      end else begin
        s_axi_rresp <= cac_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // analog front end steering; reserved channel routes nothing
  assign analog_ctrl.compare_enable = (state == cac_pkg::CAC_BUSY)
    && (channel_select != cac_pkg::CH_RESERVED);
  assign analog_ctrl.channel = channel_select;
  assign analog_ctrl.dac_code = reference_code;
  assign compare_busy = (state == cac_pkg::CAC_BUSY);

  // shared pins: analog input, or open-drain port line pulling low only
  assign analog_pin_select = pin_select;
  assign pin_o = '0;
  assign pin_oe = port_drive_low & ~pin_select;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_in <= '0;
    end else begin
      port_in <= synced[cac_pkg::PIN_N:1] | pin_select;
    end
  end
endmodule : cac_top

//--- logic/cac_pkg.sv
// constants and types for the compare converter control block
package cac_pkg;
  // bus address width and register indices; byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [7:0] CTRL_INDEX = 8'hC8;
  localparam logic [7:0] PINFN_INDEX = 8'hCA;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({CTRL_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] PINFN_ADDR = ADDR_W'({PINFN_INDEX, 2'b00});

  // control register fields
  localparam int ABOVE_BIT = 7;
  localparam int CH_HI_BIT = 6;
  localparam int CH_LO_BIT = 5;
  localparam int START_BIT = 4;
  localparam int REF_HI_BIT = 3;
  localparam int REF_LO_BIT = 0;
  localparam int REF_W = 4;
  localparam int CH_W = 2;
  localparam logic [CH_W-1:0] CH_RESERVED = 2'h0;

  // pin function register fields
  localparam int PIN_N = 3;
  localparam int PIN_HI_BIT = 2;
  localparam int PIN_LO_BIT = 0;

  localparam logic [CH_W-1:0] CH_RESET = 2'h0;
  localparam logic [REF_W-1:0] REF_RESET = 4'h0;
  localparam logic [PIN_N-1:0] PINFN_RESET = 3'h0;
  localparam logic ABOVE_RESET = 1'b0;

  // timing: one machine cycle at the documented 12 MHz oscillator
  localparam int CLK_PERIOD_NS = 8;
  localparam int MACHINE_CYCLE_NS = 1000;
  localparam int MC_CLKS = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MC_CNT_W = 8;
  localparam logic [MC_CNT_W-1:0] MC_LAST = MC_CNT_W'(MC_CLKS - 1);
  localparam int COMPARE_MC = 8;
  localparam int CMP_CNT_W = 4;
  localparam logic [CMP_CNT_W-1:0] CMP_LAST = CMP_CNT_W'(COMPARE_MC - 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic compare_enable;
    logic [CH_W-1:0] channel;
    logic [REF_W-1:0] dac_code;
  } cac_analog_t;

  typedef enum {CAC_IDLE, CAC_BUSY} cac_state_t;
endpackage : cac_pkg

//--- logic/cac_sync3.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module cac_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          level[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule : cac_sync3

//--- dv/cac_analog_model.sv
// comparator, reference converter and input selector model
`timescale 1ns/1ps
module cac_analog_model (
  input wire logic clk,
  input wire cac_pkg::cac_analog_t analog_ctrl,
  input wire logic [2:0][5:0] level,
  output logic compare_above_in
);
  logic [5:0] ref_level;
  assign ref_level = {1'b0, analog_ctrl.dac_code, 1'b0} + 6'h02;
  initial compare_above_in = 1'b0;
  always @(posedge clk) begin
    if (analog_ctrl.compare_enable) begin
      compare_above_in <= level[analog_ctrl.channel - 2'h1] > ref_level;
    end else begin
      compare_above_in <= ~compare_above_in;
    end
  end
endmodule : cac_analog_model

//--- dv/cac_top_properties.sv
// assertion checker for the compare converter control block
`timescale 1ns/1ps
module cac_top_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [cac_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire cac_pkg::cac_analog_t analog_ctrl,
  input wire logic [2:0] analog_pin_select,
  input wire logic [2:0] port_drive_low,
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe,
  input wire logic compare_busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic st;
  logic [10:0] cnt;
  assign st = s_axi_awvalid & s_axi_wvalid & s_axi_awready & s_axi_wstrb[0] & s_axi_wdata[4]
    & (s_axi_awaddr == cac_pkg::CTRL_ADDR);
  // busy cycles since the last start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 11'h000;
    end else if (st) begin
      cnt <= 11'h000;
    end else if (compare_busy) begin
      cnt <= cnt + 11'h001;
    end
  end
  property p_done; $fell(compare_busy) |-> cnt == 11'h3E8; endproperty
  a_done: assert property (p_done) else $error("run length wrong");
  property p_max; cnt <= 11'h3E8; endproperty
  a_max: assert property (p_max) else $error("run too long");
  property p_go; $rose(compare_busy) |-> $past(st); endproperty
  a_go: assert property (p_go) else $error("run without start");
  property p_idle; !compare_busy && !st |=> !compare_busy; endproperty
  a_idle: assert property (p_idle) else $error("spurious run");
  property p_rsv; analog_ctrl.compare_enable |-> compare_busy && analog_ctrl.channel != 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("enable wrong");
  property p_dac; st |=> analog_ctrl.dac_code == $past(s_axi_wdata[3:0])
    && analog_ctrl.channel == $past(s_axi_wdata[6:5]); endproperty
  a_dac: assert property (p_dac) else $error("code or channel wrong");
  property p_pin; pin_oe == (port_drive_low & ~analog_pin_select) && pin_o == 3'h0; endproperty
  a_pin: assert property (p_pin) else $error("pin steering wrong");
  property p_rd; s_axi_rvalid |-> !s_axi_rdata[4] && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rd: assert property (p_rd) else $error("read bits wrong");
  c_st: cover property (st);
  c_done: cover property ($fell(compare_busy));
  c_rd: cover property (s_axi_rvalid);
endmodule : cac_top_chk
bind cac_top cac_top_chk u_chk (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_rdata, .s_axi_rvalid, .analog_ctrl,
  .analog_pin_select, .port_drive_low, .pin_o, .pin_oe, .compare_busy);

//--- dv/testbench.sv
// self-checking bench for the compare converter control block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [cac_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ch;
  logic compare_above_in, compare_busy, above;
  cac_pkg::cac_analog_t analog_ctrl;
  logic [2:0] analog_pin_select, pin_i, pin_o, pin_oe, port_in, sel;
  logic [2:0] port_drive_low = 3'h0;
  logic [2:0][5:0] level = '0;
  logic [3:0] code;
  logic [33:0] exp_q[$];
  int fail_count = 0, n_tests = 0, cyc = 0;
  integer seed = 32'h74d7;
  always #4 clk = ~clk;
  assign pin_i = ~pin_oe; // pulled up when released
  cac_top u_dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .compare_above_in, .analog_ctrl, .analog_pin_select, .port_drive_low,
    .pin_i, .pin_o, .pin_oe, .port_in, .compare_busy);
  cac_analog_model u_ana (.clk, .analog_ctrl, .level, .compare_above_in);
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    n_tests++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [cac_pkg::ADDR_W-1:0] a, input logic [7:0] d,
    input logic [1:0] r);
    exp_q.push_back({r, 32'h0000_0000});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [cac_pkg::ADDR_W-1:0] a, input logic [7:0] d,
    input logic [1:0] r);
    exp_q.push_back({r, 24'h00_0000, d});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // response monitor and run limit
  always @(posedge clk) begin
    cyc++;
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    end
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(cac_pkg::CTRL_ADDR, 8'h00, cac_pkg::RESP_OKAY);
    rd(12'h004, 8'h00, cac_pkg::RESP_SLVERR);
    wr(12'h004, 8'hFF, cac_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      sel = 3'($random(seed));
      port_drive_low <= 3'($random(seed));
      wr(cac_pkg::PINFN_ADDR, {5'($random(seed)), sel}, cac_pkg::RESP_OKAY);
      repeat (8) @(posedge clk);
      chk({31'h0, port_in}, {31'h0, sel | ~port_drive_low});
      chk({31'h0, analog_pin_select}, {31'h0, sel});
      rd(cac_pkg::PINFN_ADDR, {5'h00, sel}, cac_pkg::RESP_OKAY);
    end
    for (int k = 0; k < 7; k++) begin
      ch = 2'(k % 3 + 1);
      code = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($random(seed));
      level <= 18'($random(seed)) | 18'h01041;
      wr(cac_pkg::CTRL_ADDR, {1'b0, ch, 1'b1, code}, cac_pkg::RESP_OKAY);
      repeat (1000) @(posedge clk);
      above = level[ch - 2'h1] > ({1'b0, code, 1'b0} + 6'h02);
      rd(cac_pkg::CTRL_ADDR, {above, ch, 1'b0, code}, cac_pkg::RESP_OKAY);
    end
    level <= above ? 18'h01041 : 18'h3FFFF;
    wr(cac_pkg::CTRL_ADDR, {1'b0, ch, 1'b0, ~code}, cac_pkg::RESP_OKAY);
    repeat (1000) @(posedge clk);
    rd(cac_pkg::CTRL_ADDR, {above, ch, 1'b0, ~code}, cac_pkg::RESP_OKAY);
    wr(cac_pkg::CTRL_ADDR, {1'b0, ch, 1'b1, ~code}, cac_pkg::RESP_OKAY);
    repeat (500) @(posedge clk);
    rd(cac_pkg::CTRL_ADDR, {above, ch, 1'b0, ~code}, cac_pkg::RESP_OKAY);
    wr(cac_pkg::CTRL_ADDR, {1'b0, ch, 1'b1, ~code}, cac_pkg::RESP_OKAY);
    repeat (1000) @(posedge clk);
    rd(cac_pkg::CTRL_ADDR, {~above, ch, 1'b0, ~code}, cac_pkg::RESP_OKAY);
    wr(cac_pkg::CTRL_ADDR, {1'b0, 2'h0, 1'b1, code}, cac_pkg::RESP_OKAY);
    repeat (1010) @(posedge clk);
    // reserved channel: comparator disabled and toggling each clock, synchronised level holds the last result
    rd(cac_pkg::CTRL_ADDR, {~above, 2'h0, 1'b0, code}, cac_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : testbench
